/* logic/spplc_pkg.sv */
// Constants, types and helpers shared by both ends of the serial port pair lane link.
// Assumes one 10 MHz clock, and lane symbols modelled as 3-bit code-group classes.
//
// What this block does
// - Even port runs 4x or 1x; odd only 1x.
// - 4x: even owns lanes; 1x: A even, B odd.
// - In 4x only the even port carries traffic.
// - 4x odd port powered, registers kept, no lanes.
// - Odd port stays powered unless powered down.
// - Odd port down by pin or narrow bit.
// - Dual 1x needs both pins and bits clear.
// - Sample power-down pins once after reset release.
// - Port 0 ignores pin; register write only.
// - Sampled pins held in register, overwritable anytime.
// - After reset send commas on every lane in use.
// - Sync after first comma plus 127 clean.
// - Only sync code groups before both ends synced; the code waits only for its own receive lanes to sync.
// - Synced 4x port sends alignment columns periodically.
// - Aligned after four clean alignment columns.
// - Partial alignment column restarts alignment.
// - Errors or partial rows adjust lane buffering.
// - Independent tx/rx lane reversal, only in 4x.
// - Reversed 4x facing 1x partner falls to lane A.
// - Reconfiguring to 1x cancels lane reversal.
`default_nettype none

package spplc_pkg;

    // =====================================================================
    // Lane symbols
    typedef logic [2:0] spplc_sym_t;
    typedef logic [3:0][2:0] spplc_col_t;
    localparam int LANES = 4;
    localparam spplc_sym_t SYM_IDLE = 3'h0;
    localparam spplc_sym_t SYM_K = 3'h1;
    localparam spplc_sym_t SYM_A = 3'h2;
    localparam spplc_sym_t SYM_DATA = 3'h3;
    localparam spplc_sym_t SYM_ERR = 3'h4;

    // =====================================================================
    // Timing counts
    localparam logic [7:0] SYNC_MORE = 8'h7f;
    localparam logic [7:0] SYNC_DONE = 8'h01 + SYNC_MORE;
    localparam logic [2:0] ALIGN_COLS = 3'h4;
    localparam logic [1:0] A_PERIOD = 2'h3;
    localparam logic [1:0] SAMPLE_DELAY = 2'h2;
    localparam int CLK_PERIOD_NS = 100;
    localparam int FAILDOWN_TIME_NS = 100000;
    localparam logic [9:0] FAILDOWN_CYCLES = 10'(FAILDOWN_TIME_NS / CLK_PERIOD_NS);

    // =====================================================================
    // Register map
    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam int CFG_WIDE_MAC_POWERDOWN_BIT = 0;
    localparam int CFG_NARROW_PORT_POWERDOWN_BIT = 1;
    localparam int CFG_MODE4X = 2;
    localparam int CFG_SWAP_TX = 3;
    localparam int CFG_SWAP_RX = 4;
    localparam logic [4:0] CFG_RESET = 5'h04;
    localparam int STAT_EVEN_PWR = 0;
    localparam int STAT_ODD_PWR = 1;
    localparam int STAT_SYNC = 2;
    localparam int STAT_ALIGNED = 6;
    localparam int STAT_FELL = 7;
    localparam int STAT_EVEN_UP = 8;
    localparam int STAT_ODD_UP = 9;

    // =====================================================================
    // Alignment state
    typedef enum logic [1:0] {
        AL_SYNC = 2'b00,
        AL_HUNT = 2'b01,
        AL_DONE = 2'b10
    } spplc_al_t;

    // Next value of a lane sync counter; errors or stray symbols before sync restart it.
    function automatic logic [7:0] sync_step(logic [7:0] cnt, spplc_sym_t s);
        logic [7:0] r;
        r = 8'h00;
        if (s == SYM_ERR) begin
            r = 8'h00;
        end else if (cnt == SYNC_DONE) begin
            r = cnt;
        end else if (s == SYM_K) begin
            r = cnt + 8'h01;
        end
        return r;
    endfunction

    // Reverses lane order when en is high.
    function automatic spplc_col_t lane_swap(spplc_col_t v, logic en);
        spplc_col_t r;
        r = v;
        if (en) begin
            for (int i = 0; i < LANES; i++) begin
                r[i] = v[LANES - 1 - i];
            end
        end
        return r;
    endfunction

    // Marks lanes holding a given symbol.
    function automatic logic [3:0] lanes_with(spplc_col_t v, spplc_sym_t s);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < LANES; i++) begin
            r[i] = (v[i] == s);
        end
        return r;
    endfunction

endpackage

`default_nettype wire

/* logic/spplc_lane_if.sv */
// Four serial lanes between the switch port pair and its link partner.
// Assumes both ends run on the same clock; one symbol per lane per cycle.
`timescale 1ns/100ps
`default_nettype none

interface spplc_lane_if;
    import spplc_pkg::*;
    // Symbols sent by the port pair and by the partner, indexed by physical lane A..D.
    spplc_col_t dev_tx;
    spplc_col_t ptn_tx;
    modport dev (output dev_tx, input ptn_tx);
    modport ptn (output ptn_tx, input dev_tx);
endinterface

`default_nettype wire

/* logic/spplc_pair.sv */
// Lane control for an even/odd serial port pair sharing four lanes.
// Assumes a plain register port, power-down pins from the board, partner on the lane interface.
`timescale 1ns/100ps
`default_nettype none

module spplc_pair
    import spplc_pkg::*;
#(
    parameter logic IS_PORT0 = 1'b0
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Board pins
    input wire logic even_powerdown_pin,
    input wire logic odd_powerdown_pin,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Status
    output logic even_powered,
    output logic odd_powered,
    output logic even_link_up,
    output logic odd_link_up,
    // Lanes
    spplc_lane_if.dev lif
);

    // =====================================================================
    // Pin synchronisers and one-time sampling
    logic even_pin_q1, even_pin_q2, odd_pin_q1, odd_pin_q2;
    logic [1:0] samp_cnt_r;
    logic sampled_r;

    // Pins are asynchronous to the clock, so two flops before use.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            even_pin_q1 <= 1'b0;
            even_pin_q2 <= 1'b0;
            odd_pin_q1 <= 1'b0;
            odd_pin_q2 <= 1'b0;
        end else begin
            even_pin_q1 <= even_powerdown_pin;
            even_pin_q2 <= even_pin_q1;
            odd_pin_q1 <= odd_powerdown_pin;
            odd_pin_q2 <= odd_pin_q1;
        end
    end

    // Wait for the synchroniser to fill, then sample exactly once.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            samp_cnt_r <= 2'h0;
            sampled_r <= 1'b0;
        end else if (!sampled_r) begin
            samp_cnt_r <= samp_cnt_r + 2'h1;
            sampled_r <= (samp_cnt_r == SAMPLE_DELAY);
        end
    end

    // =====================================================================
    // Configuration register
    logic [4:0] cfg_r;
    logic fell_down_r;
    logic mode4x, even_on, odd_on, odd_phy, wide, swap_tx, swap_rx;

    // Pin states land in the register once; any later write overrides them.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_r <= CFG_RESET;
        end else if (!sampled_r && samp_cnt_r == SAMPLE_DELAY) begin
            cfg_r[CFG_WIDE_MAC_POWERDOWN_BIT] <= IS_PORT0 ? cfg_r[CFG_WIDE_MAC_POWERDOWN_BIT] : even_pin_q2;
            cfg_r[CFG_NARROW_PORT_POWERDOWN_BIT] <= odd_pin_q2;
        end else if (wr && addr == CFG_OFS) begin
            cfg_r <= wdata[4:0];
        end
    end

    assign mode4x = cfg_r[CFG_MODE4X];
    assign even_on = sampled_r && !cfg_r[CFG_WIDE_MAC_POWERDOWN_BIT];
    assign odd_on = sampled_r && !cfg_r[CFG_NARROW_PORT_POWERDOWN_BIT];
    // The odd port keeps its registers in 4x but never reaches a lane.
    assign odd_phy = odd_on && !mode4x;
    assign wide = even_on && mode4x && !fell_down_r;
    // Reversal only counts while running wide; 1x or fail-down cancels it.
    assign swap_tx = cfg_r[CFG_SWAP_TX] && wide;
    assign swap_rx = cfg_r[CFG_SWAP_RX] && wide;

    // =====================================================================
    // Per-lane synchronisation on physical lanes
    logic [3:0][7:0] sync_cnt_r;
    logic [3:0] lane_live, lane_sync;

    assign lane_live[0] = even_on;
    assign lane_live[1] = wide || odd_phy;
    assign lane_live[2] = wide;
    assign lane_live[3] = wide;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_cnt_r <= '0;
        end else begin
            for (int i = 0; i < LANES; i++) begin
                sync_cnt_r[i] <= lane_live[i] ? sync_step(sync_cnt_r[i], lif.ptn_tx[i]) : 8'h00;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            lane_sync[i] = (sync_cnt_r[i] == SYNC_DONE);
        end
    end

    // =====================================================================
    // Lane deskew and alignment
    spplc_col_t rx_log, prev_r, col;
    logic [3:0] dly_r, col_a, col_err, adj;
    spplc_al_t al_st_r;
    logic [2:0] al_cnt_r;
    logic all_a, some_a, bad_col;

    assign rx_log = lane_swap(lif.ptn_tx, swap_rx);

    // A lane may be held back one column to absorb skew between lanes.
    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            col[i] = dly_r[i] ? prev_r[i] : rx_log[i];
        end
    end

    assign col_a = lanes_with(col, SYM_A);
    assign col_err = lanes_with(col, SYM_ERR);
    assign all_a = (col_a == 4'hf);
    assign some_a = (col_a != 4'h0);
    assign bad_col = (some_a && !all_a) || (col_err != 4'h0);
    // Lanes that were early or errored get their buffering flipped.
    assign adj = (some_a && !all_a) ? (col_a | col_err) : col_err;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_r <= '0;
            dly_r <= 4'h0;
        end else begin
            prev_r <= rx_log;
            if (al_st_r != AL_SYNC && bad_col) begin
                dly_r <= dly_r ^ adj;
            end
        end
    end

    // Alignment only starts once every lane is in sync.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            al_st_r <= AL_SYNC;
            al_cnt_r <= 3'h0;
        end else if (!(wide && lane_sync == 4'hf)) begin
            al_st_r <= AL_SYNC;
            al_cnt_r <= 3'h0;
        end else begin
            unique case (al_st_r)
                AL_SYNC: begin
                    al_st_r <= AL_HUNT;
                    al_cnt_r <= 3'h0;
                end
                AL_HUNT: begin
                    if (bad_col) begin
                        al_cnt_r <= 3'h0;
                    end else if (all_a) begin
                        al_cnt_r <= al_cnt_r + 3'h1;
                        if (al_cnt_r + 3'h1 == ALIGN_COLS) begin
                            al_st_r <= AL_DONE;
                        end
                    end
                end
                AL_DONE: begin
                    if (bad_col) begin
                        al_st_r <= AL_HUNT;
                        al_cnt_r <= 3'h0;
                    end
                end
                default: begin
                    al_st_r <= AL_SYNC;
                end
            endcase
        end
    end

    // =====================================================================
    // Fail-down to one lane
    logic [9:0] fd_cnt_r;

    // Lane A in sync while lanes B to D are not all in sync means a single-lane partner.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fd_cnt_r <= 10'h000;
            fell_down_r <= 1'b0;
        end else if (!(mode4x && even_on)) begin
            fd_cnt_r <= 10'h000;
            fell_down_r <= 1'b0;
        end else if (!fell_down_r && lif.ptn_tx[0] != SYM_IDLE && lane_sync[0]
                     && lane_sync[3:1] != 3'h7) begin
            fd_cnt_r <= fd_cnt_r + 10'h001;
            if (fd_cnt_r == FAILDOWN_CYCLES - 10'h001) begin
                fell_down_r <= 1'b1;
            end
        end else begin
            fd_cnt_r <= 10'h000;
        end
    end

    // =====================================================================
    // Transmit
    logic [1:0] a_cnt_r;
    spplc_col_t tx_nxt, tx_r;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            a_cnt_r <= 2'h0;
        end else begin
            a_cnt_r <= a_cnt_r + 2'h1;
        end
    end

    // Commas until synced; in 4x then periodic alignment columns and data once aligned, in 1x data once the lane is synced.
    always_comb begin
        tx_nxt = '0;
        if (wide) begin
            for (int i = 0; i < LANES; i++) begin
                if (lane_sync != 4'hf) begin
                    tx_nxt[i] = SYM_K;
                end else if (a_cnt_r == A_PERIOD) begin
                    tx_nxt[i] = SYM_A;
                end else begin
                    tx_nxt[i] = (al_st_r == AL_DONE) ? SYM_DATA : SYM_K;
                end
            end
        end else begin
            if (even_on) begin
                tx_nxt[0] = lane_sync[0] ? SYM_DATA : SYM_K;
            end
            if (odd_phy) begin
                tx_nxt[1] = lane_sync[1] ? SYM_DATA : SYM_K;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_r <= '0;
        end else begin
            tx_r <= lane_swap(tx_nxt, swap_tx);
        end
    end

    assign lif.dev_tx = tx_r;

    // =====================================================================
    // Status outputs and register reads
    logic [9:0] stat;

    assign stat = {odd_link_up, even_link_up, fell_down_r, (al_st_r == AL_DONE),
                   lane_sync, odd_on, even_on};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            even_powered <= 1'b0;
            odd_powered <= 1'b0;
            even_link_up <= 1'b0;
            odd_link_up <= 1'b0;
        end else begin
            even_powered <= even_on;
            odd_powered <= odd_on;
            even_link_up <= wide ? (al_st_r == AL_DONE) : (even_on && lane_sync[0]);
            odd_link_up <= odd_phy && lane_sync[1];
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else if (rd && addr == CFG_OFS) begin
            rdata <= {27'h0, cfg_r};
        end else if (rd && addr == STAT_OFS) begin
            rdata <= {22'h0, stat};
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule

`default_nettype wire

/* logic/spplc_partner.sv */
// Link partner port logic, 4x or 1x, on the far side of the four lanes.
// Assumes the same clock as the port pair; no lane reversal on this side.
`timescale 1ns/100ps
`default_nettype none

module spplc_partner
    import spplc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // User controls
    input wire logic enable,
    input wire logic use_1x,
    // Status
    output logic synced,
    output logic aligned,
    // Lanes
    spplc_lane_if.ptn lif
);

    // =====================================================================
    // Lane synchronisation
    logic [3:0][7:0] sync_cnt_r;
    logic [3:0] used, lane_sync;
    logic all_sync;

    assign used = !enable ? 4'h0 : (use_1x ? 4'h1 : 4'hf);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sync_cnt_r <= '0;
        end else begin
            for (int i = 0; i < LANES; i++) begin
                sync_cnt_r[i] <= used[i] ? sync_step(sync_cnt_r[i], lif.dev_tx[i]) : 8'h00;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            lane_sync[i] = (sync_cnt_r[i] == SYNC_DONE) || !used[i];
        end
    end

    assign all_sync = enable && (lane_sync == 4'hf);

    // =====================================================================
    // Alignment for the wide case
    logic [3:0] col_a;
    logic [2:0] al_cnt_r;
    logic al_r;

    assign col_a = lanes_with(lif.dev_tx, SYM_A);

    // Four whole columns align; any partial column starts over.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            al_cnt_r <= 3'h0;
            al_r <= 1'b0;
        end else if (!all_sync || use_1x) begin
            al_cnt_r <= 3'h0;
            al_r <= 1'b0;
        end else if (col_a != 4'h0 && col_a != 4'hf) begin
            al_cnt_r <= 3'h0;
            al_r <= 1'b0;
        end else if (col_a == 4'hf && !al_r) begin
            al_cnt_r <= al_cnt_r + 3'h1;
            al_r <= (al_cnt_r + 3'h1 == ALIGN_COLS);
        end
    end

    // =====================================================================
    // Transmit
    logic [1:0] a_cnt_r;
    spplc_col_t tx_nxt;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            a_cnt_r <= 2'h0;
        end else begin
            a_cnt_r <= a_cnt_r + 2'h1;
        end
    end

    always_comb begin
        tx_nxt = '0;
        for (int i = 0; i < LANES; i++) begin
            if (!used[i]) begin
                tx_nxt[i] = SYM_IDLE;
            end else if (!all_sync) begin
                tx_nxt[i] = SYM_K;
            end else if (use_1x) begin
                tx_nxt[i] = SYM_DATA;
            end else if (a_cnt_r == A_PERIOD) begin
                tx_nxt[i] = SYM_A;
            end else begin
                tx_nxt[i] = al_r ? SYM_DATA : SYM_K;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lif.ptn_tx <= '0;
            synced <= 1'b0;
            aligned <= 1'b0;
        end else begin
            lif.ptn_tx <= tx_nxt;
            synced <= all_sync;
            aligned <= al_r;
        end
    end

endmodule

`default_nettype wire

/* verification/spplc_properties.sv */
// Concurrent checks on the four lanes between the port pair and its link partner.
// Assumes one clock domain and the lane signals handed in as plain inputs.
`timescale 1ns/100ps
`default_nettype none

module spplc_properties
    import spplc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Lanes
    input wire spplc_col_t dev_tx,
    input wire spplc_col_t ptn_tx
);
    // =====================================================================
    // Helpers
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic [7:0] pk_run_r;
    logic [7:0] dk_run_r;
    logic pair_rx_ok_r;
    logic ptn_rx_ok_r;
    logic [2:0] pa_cols_r;

    function automatic logic all_a(spplc_col_t c);
        return (c[0] == SYM_A) && (c[1] == SYM_A) && (c[2] == SYM_A) && (c[3] == SYM_A);
    endfunction

    function automatic logic any_a(spplc_col_t c);
        return (c[0] == SYM_A) || (c[1] == SYM_A) || (c[2] == SYM_A) || (c[3] == SYM_A);
    endfunction

    // Comma streaks on lane A; a flag remembers that a full streak has ever been seen.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pk_run_r <= 8'h00;
            dk_run_r <= 8'h00;
            pair_rx_ok_r <= 1'b0;
            ptn_rx_ok_r <= 1'b0;
        end else begin
            pk_run_r <= (ptn_tx[0] != SYM_K) ? 8'h00 : pk_run_r + {7'h0, pk_run_r != 8'hff};
            dk_run_r <= (dev_tx[0] != SYM_K) ? 8'h00 : dk_run_r + {7'h0, dk_run_r != 8'hff};
            pair_rx_ok_r <= pair_rx_ok_r | (pk_run_r >= SYNC_DONE);
            ptn_rx_ok_r <= ptn_rx_ok_r | (dk_run_r >= SYNC_DONE);
        end
    end

    // Whole alignment columns reaching the pair; a partial one starts the count again.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pa_cols_r <= 3'h0;
        end else if (any_a(ptn_tx) && !all_a(ptn_tx)) begin
            pa_cols_r <= 3'h0;
        end else if (all_a(ptn_tx) && pa_cols_r != ALIGN_COLS) begin
            pa_cols_r <= pa_cols_r + 3'h1;
        end
    end

    // =====================================================================
    // Sequences
    sequence s_ptn_all_a;
        all_a(ptn_tx);
    endsequence

    sequence s_ptn_quiet3;
        (!any_a(ptn_tx)) [*3];
    endsequence

    sequence s_dev_all_a;
        all_a(dev_tx);
    endsequence

    sequence s_dev_quiet3;
        (!any_a(dev_tx)) [*3];
    endsequence

    // =====================================================================
    // Assertions
    AST_PTN_A_SPACING: assert property (s_ptn_all_a |=> s_ptn_quiet3)
        else $error("partner alignment columns closer than four cycles");
    AST_DEV_A_SPACING: assert property (s_dev_all_a |=> s_dev_quiet3)
        else $error("pair alignment columns closer than four cycles");
    AST_DEV_A_WHOLE: assert property (any_a(dev_tx) |-> all_a(dev_tx))
        else $error("pair sent a partial alignment column");
    AST_PTN_A_WHOLE: assert property (any_a(ptn_tx) |-> all_a(ptn_tx))
        else $error("partner sent a partial alignment column");
    AST_DEV_DATA_AFTER_SYNC: assert property ((dev_tx[0] == SYM_DATA) |-> pair_rx_ok_r)
        else $error("pair sent data before a full comma streak arrived");
    AST_PTN_DATA_AFTER_SYNC: assert property ((ptn_tx[0] == SYM_DATA) |-> ptn_rx_ok_r)
        else $error("partner sent data before a full comma streak arrived");
    AST_DEV_ALIGN_FIRST: assert property ((dev_tx[3] == SYM_DATA) |-> (pa_cols_r == ALIGN_COLS))
        else $error("pair sent 4x data before four clean alignment columns");
    AST_PTN_K_AFTER_RESET: assert property ($fell(rst) |-> ##[0:8] (ptn_tx[0] == SYM_K))
        else $error("partner sent no comma after reset release");
    AST_CD_TOGETHER: assert property ((dev_tx[2] == SYM_IDLE) == (dev_tx[3] == SYM_IDLE))
        else $error("lanes C and D used apart from each other");
endmodule

`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench: port pair and link partner joined on one lane interface.
// Assumes package, interface and both ends compiled first; one 10 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module testbench
    import spplc_pkg::*;
;
    // =====================================================================
    // Signals and instances
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic even_pd = 1'b0;
    logic odd_pd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic use_1x = 1'b0;
    logic [31:0] rdata, rdata0, v, v0;
    logic even_powered, odd_powered, even_link_up, odd_link_up, even_powered0;
    logic synced, aligned;
    int failures = 0;
    int n_checks = 0;

    spplc_lane_if lif();
    spplc_lane_if lif0();
    // The port 0 copy has no partner, so its receive lanes stay idle.
    assign lif0.ptn_tx = '0;

    spplc_pair i_spplc_pair (.sys_clk(sys_clk), .rst(rst), .even_powerdown_pin(even_pd),
        .odd_powerdown_pin(odd_pd), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .even_powered(even_powered), .odd_powered(odd_powered),
        .even_link_up(even_link_up), .odd_link_up(odd_link_up), .lif(lif.dev));
    spplc_pair #(.IS_PORT0(1'b1)) i_spplc_pair_p0 (.sys_clk(sys_clk), .rst(rst),
        .even_powerdown_pin(even_pd), .odd_powerdown_pin(odd_pd), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata0), .even_powered(even_powered0),
        .odd_powered(), .even_link_up(), .odd_link_up(), .lif(lif0.dev));
    spplc_partner i_spplc_partner (.sys_clk(sys_clk), .rst(rst), .enable(1'b1),
        .use_1x(use_1x), .synced(synced), .aligned(aligned), .lif(lif.ptn));
    spplc_properties i_spplc_properties (.sys_clk(sys_clk), .rst(rst),
        .dev_tx(lif.dev_tx), .ptn_tx(lif.ptn_tx));

    // Free-running 10 MHz clock.
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    // =====================================================================
    // Shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        v = rdata;
        v0 = rdata0;
    endtask

    // Pins must be stable from release until they are sampled, so they are set first.
    task automatic do_reset(input logic ep, input logic op);
        @(posedge sys_clk);
        even_pd <= ep;
        odd_pd <= op;
        rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(negedge sys_clk);
        check("early_power", {30'h0, even_powered, odd_powered}, 32'h0);
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic wait_link(input int max);
        int n;
        n = 0;
        while (even_link_up !== 1'b1 && n < max) begin
            @(posedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // =====================================================================
    // Scenarios
    task automatic test_pins();
        do_reset(1'b1, 1'b1);
        @(negedge sys_clk);
        check("even_powered", {31'h0, even_powered}, 32'h0);
        check("odd_powered", {31'h0, odd_powered}, 32'h0);
        check("port0_even_powered", {31'h0, even_powered0}, 32'h1);
        rd_reg(CFG_OFS);
        check("cfg", v, 32'h7);
        check("port0_cfg", v0, 32'h6);
        rd_reg(8'h08);
        check("unmapped", v, 32'h0);
        wr_reg(CFG_OFS, 32'h4);
        repeat (3) @(negedge sys_clk);
        check("even_on", {31'h0, even_powered}, 32'h1);
        check("odd_on", {31'h0, odd_powered}, 32'h1);
        wr_reg(CFG_OFS, 32'h6);
        repeat (3) @(negedge sys_clk);
        check("odd_off", {31'h0, odd_powered}, 32'h0);
        check("even_kept", {31'h0, even_powered}, 32'h1);
        $display("test pins done");
    endtask

    task automatic test_4x();
        use_1x <= 1'b0;
        do_reset(1'b0, 1'b0);
        wait_link(600);
        check("even_link_up", {31'h0, even_link_up}, 32'h1);
        check("partner_aligned", {31'h0, aligned}, 32'h1);
        check("odd_link_up", {31'h0, odd_link_up}, 32'h0);
        rd_reg(STAT_OFS);
        check("status_4x", v, 32'h17f);
        $display("test 4x done");
    endtask

    // A reversed wide port facing a single-lane partner has to drop to lane A.
    task automatic test_faildown();
        use_1x <= 1'b1;
        do_reset(1'b0, 1'b1);
        wr_reg(CFG_OFS, 32'h1e);
        wait_link(2000);
        rd_reg(STAT_OFS);
        check("status_fell", v & 32'h180, 32'h180);
        check("partner_synced", {31'h0, synced}, 32'h1);
        $display("test faildown done");
    endtask

    task automatic test_1x();
        use_1x <= 1'b1;
        do_reset(1'b0, 1'b0);
        wr_reg(CFG_OFS, 32'h18);
        wait_link(600);
        rd_reg(STAT_OFS);
        check("status_1x", v & 32'h380, 32'h100);
        check("odd_powered_1x", {31'h0, odd_powered}, 32'h1);
        check("lane_b", {29'h0, lif.dev_tx[1]}, {29'h0, SYM_K});
        check("lane_d", {29'h0, lif.dev_tx[3]}, {29'h0, SYM_IDLE});
        check("odd_link_1x", {31'h0, odd_link_up}, 32'h0);
        $display("test 1x done");
    endtask

    // =====================================================================
    // Main sequence and watchdog
    initial begin
        test_pins();
        test_4x();
        test_faildown();
        test_1x();
        complete_run();
    end

    // The tests need some 1500 cycles; a far longer wait means something hung.
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("watchdog expired");
        complete_run();
    end
endmodule

`default_nettype wire
